// >>> src/spm_bit_vote.sv
// three-sample majority bit detector for the asynchronous receiver
// assumes slice_idx counts 0..15 per bit and rxd_in is synchronous
`timescale 1ns/1ps
module spm_bit_vote import spm_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // slice timing
  input wire logic active,
  input wire logic slice_tick,
  input wire logic [3:0] slice_idx,
  input wire logic rxd_in,
  // decided bit
  output logic bit_strobe,
  output logic bit_val
);
  logic [1:0] smp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      smp_q <= 2'h3;
    end else if (clk_en && active && slice_tick) begin
      if (slice_idx == SAMPLE_A) smp_q[0] <= rxd_in;
      if (slice_idx == SAMPLE_B) smp_q[1] <= rxd_in;
    end
  end

  // third sample is taken live so the decision lands at slice ten
  assign bit_strobe = active && slice_tick && (slice_idx == SAMPLE_C);
  assign bit_val = spm_majority(smp_q[0], smp_q[1], rxd_in);

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SAMPLE_A: assert property ((clk_en && active && slice_tick && slice_idx == SAMPLE_A)
      |=> smp_q[0] == $past(rxd_in))
    else $error("first vote sample not taken at slice eight");
endmodule // spm_bit_vote

// >>> src/spm_pkg.sv
// constants, layouts and types shared by the serial port design
// assumes a 40 MHz core clock and an AXI4-Lite register bus
package spm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_BUF = 4'h4;
  localparam logic [3:0] OFF_PWR = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;

  localparam int unsigned CTL_RX_DONE = 0;
  localparam int unsigned CTL_TX_DONE = 1;
  localparam int unsigned CTL_RX_NINTH = 2;
  localparam int unsigned CTL_TX_NINTH = 3;
  localparam int unsigned CTL_REN = 4;
  localparam int unsigned CTL_MPC = 5;
  localparam int unsigned CTL_MSEL1 = 6;
  localparam int unsigned CTL_MSEL0 = 7;
  localparam int unsigned PWR_M0_FAST = 0;
  localparam int unsigned PWR_BAUD_DBL = 7;
  localparam int unsigned STAT_TX_BUSY = 0;
  localparam int unsigned STAT_RX_BUSY = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] SLICE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] RX_NINTH_IDX = 4'h9;
  localparam logic [3:0] RX_LAST_10 = 4'h9;
  localparam logic [3:0] RX_LAST_11 = 4'hA;
  localparam logic [3:0] TX_BITS_10 = 4'hA;
  localparam logic [3:0] TX_BITS_11 = 4'hB;
  localparam logic [3:0] M0_PER_FAST = 4'h4;
  localparam logic [3:0] M0_PER_SLOW = 4'hC;
  localparam logic [3:0] M0_LAST_BIT = 4'h7;
  localparam logic [1:0] M2_DIV_FAST = 2'h1;
  localparam logic [1:0] M2_DIV_SLOW = 2'h3;

  typedef enum logic [1:0] {SPM_SYNC, SPM_ASYNC10, SPM_ASYNC11, SPM_ASYNC11T} spm_mode_t;
  typedef enum logic {SPM_RX_IDLE, SPM_RX_BIT} spm_rx_st_t;
  typedef enum logic [1:0] {SPM_TX_IDLE, SPM_TX_SYNC, SPM_TX_SHIFT} spm_tx_st_t;

  function automatic logic spm_majority(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction
endpackage

// >>> src/spm_serial_port.sv
// four-mode serial port with an AXI4-Lite register slave
// assumes pins and timer_ovf are synchronous to core_clk
// What this block does
// - bit time split into sixteen slices
// - sample slices eight to ten, majority vote
// - nonzero start bit aborts, watch edge again
// - one shift after eight data, then load
// - load only if flag clear and compare passes
// - mode 1 stop bit into ninth bit field
// - after mid stop bit, watch for falling edge
// - mode 2 frame: start, eight data, ninth, stop
// - eleven-bit modes keep received ninth bit
// - mode 2 rate osc/32 or osc/64
// - transmit starts at slice counter roll-over
// - mode 3 equals mode 2, timer rate
// - buffer write starts a transmission, except in mode 0 while busy
// - mode 0 receive when flag clear, enabled
// - async receive starts on start bit if enabled
// - mode field picks one of four modes
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module spm_serial_port import spm_pkg::*; (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // baud source
  input wire logic timer_ovf,
  // serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd
);
  // control state
  spm_mode_t mode_q;
  logic mpc_q, ren_q, tx_ninth_q, rx_ninth_q, tx_done_q, rx_done_q;
  logic dbl_q, m0_fast_q;
  logic [7:0] rx_buf_q;
  // bus state
  logic aw_hold_q, w_hold_q, b_q, r_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic wr_fire, wr_ctrl, wr_buf, wr_pwr, wr_hit;
  // async transmit
  spm_tx_st_t tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q, tx_slice_q;
  logic tx_line_q, tx_roll, tx_fin_a;
  // async receive
  spm_rx_st_t rx_st_q;
  logic [3:0] rx_slice_q, rx_idx_q, rx_last;
  logic [7:0] rx_sh_q;
  logic rx_prev_q, rx_load, bit_strobe, bit_val, slice_tick;
  // mode 0 engine
  logic m0_busy_q, m0_tx_q, m0_sclk_q, m0_dout_q;
  logic [3:0] m0_ph_q, m0_cnt_q, m0_per, m0_half;
  logic [7:0] m0_sh_q;
  logic m0_end, m0_rx_go;

  spm_tick_gen u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .mode(mode_q),
    .baud_dbl(dbl_q),
    .timer_ovf(timer_ovf),
    .slice_tick(slice_tick)
  );

  spm_bit_vote u_vote (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .active(rx_st_q == SPM_RX_BIT),
    .slice_tick(slice_tick),
    .slice_idx(rx_slice_q),
    .rxd_in(rxd_in),
    .bit_strobe(bit_strobe),
    .bit_val(bit_val)
  );

  // bus handshakes drop while frozen so nothing is taken and then lost
  assign s_axi_awready = clk_en && !aw_hold_q && !b_q;
  assign s_axi_wready = clk_en && !w_hold_q && !b_q;
  assign s_axi_arready = clk_en && !r_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  assign wr_fire = clk_en && aw_hold_q && w_hold_q && !b_q;
  always_comb begin
    wr_ctrl = 1'b0;
    wr_buf = 1'b0;
    wr_pwr = 1'b0;
    wr_hit = 1'b1;
    if (aw_addr_q == OFF_CTRL) begin
      wr_ctrl = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFF_BUF) begin
      wr_buf = wr_fire && w_lane_q;
    end else if (aw_addr_q == OFF_PWR) begin
      wr_pwr = wr_fire && w_lane_q;
    end else if (aw_addr_q != OFF_STAT) begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      b_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        b_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_q && s_axi_bready) begin
        b_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        r_q <= 1'b1;
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_OKAY;
        if (s_axi_araddr == OFF_CTRL) begin
          rdata_q[7:0] <= {mode_q[0], mode_q[1], mpc_q, ren_q, tx_ninth_q, rx_ninth_q,
                           tx_done_q, rx_done_q};
        end else if (s_axi_araddr == OFF_BUF) begin
          rdata_q[7:0] <= rx_buf_q;
        end else if (s_axi_araddr == OFF_PWR) begin
          rdata_q[PWR_BAUD_DBL] <= dbl_q;
          rdata_q[PWR_M0_FAST] <= m0_fast_q;
        end else if (s_axi_araddr == OFF_STAT) begin
          rdata_q[STAT_TX_BUSY] <= (tx_st_q != SPM_TX_IDLE) || (m0_busy_q && m0_tx_q);
          rdata_q[STAT_RX_BUSY] <= (rx_st_q != SPM_RX_IDLE) || (m0_busy_q && !m0_tx_q);
        end else begin
          rresp_q <= RESP_SLVERR;
        end
      end else if (r_q && s_axi_rready) begin
        r_q <= 1'b0;
      end
    end
  end

  // configuration written by software before traffic
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= SPM_SYNC;
      mpc_q <= 1'b0;
      ren_q <= 1'b0;
      tx_ninth_q <= 1'b0;
      dbl_q <= 1'b0;
      m0_fast_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        mode_q <= spm_mode_t'({w_data_q[CTL_MSEL1], w_data_q[CTL_MSEL0]});
        mpc_q <= w_data_q[CTL_MPC];
        ren_q <= w_data_q[CTL_REN];
        tx_ninth_q <= w_data_q[CTL_TX_NINTH];
      end
      if (wr_pwr) begin
        dbl_q <= w_data_q[PWR_BAUD_DBL];
        m0_fast_q <= w_data_q[PWR_M0_FAST];
      end
    end
  end

  // done flags: a hardware set wins over a software write in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_done_q <= 1'b0;
      tx_done_q <= 1'b0;
      rx_ninth_q <= 1'b0;
      rx_buf_q <= 8'h00;
    end else if (clk_en) begin
      if (rx_load || (m0_end && !m0_tx_q)) begin
        rx_done_q <= 1'b1;
      end else if (wr_ctrl) begin
        rx_done_q <= w_data_q[CTL_RX_DONE];
      end
      if (tx_fin_a || (m0_end && m0_tx_q)) begin
        tx_done_q <= 1'b1;
      end else if (wr_ctrl) begin
        tx_done_q <= w_data_q[CTL_TX_DONE];
      end
      if (rx_load) begin
        rx_ninth_q <= bit_val;
      end else if (wr_ctrl) begin
        rx_ninth_q <= w_data_q[CTL_RX_NINTH];
      end
      if (rx_load) begin
        rx_buf_q <= rx_sh_q;
      end else if (m0_end && !m0_tx_q) begin
        rx_buf_q <= m0_sh_q;
      end
    end
  end

  // async transmit, paced by a free-running slice counter
  assign tx_roll = slice_tick && (tx_slice_q == SLICE_LAST);
  assign tx_fin_a = (tx_st_q == SPM_TX_SHIFT) && tx_roll && (tx_left_q == 4'h0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_slice_q <= 4'h0;
    end else if (clk_en && slice_tick) begin
      tx_slice_q <= tx_slice_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= SPM_TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else if (clk_en) begin
      if (wr_buf && mode_q != SPM_SYNC) begin
        tx_st_q <= SPM_TX_SYNC;
        tx_sh_q <= {1'b1, (mode_q == SPM_ASYNC10) ? 1'b1 : tx_ninth_q, w_data_q, 1'b0};
        tx_left_q <= (mode_q == SPM_ASYNC10) ? TX_BITS_10 : TX_BITS_11;
      end else if (tx_roll) begin
        case (tx_st_q)
          SPM_TX_SYNC, SPM_TX_SHIFT: begin
            if (tx_st_q == SPM_TX_SHIFT && tx_left_q == 4'h0) begin
              tx_st_q <= SPM_TX_IDLE;
              tx_line_q <= 1'b1;
            end else begin
              tx_st_q <= SPM_TX_SHIFT;
              tx_line_q <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_left_q <= tx_left_q - 4'h1;
            end
          end
          default: tx_line_q <= 1'b1;
        endcase
      end
    end
  end

  // async receive
  assign rx_last = (mode_q == SPM_ASYNC10) ? RX_LAST_10 : RX_LAST_11;
  assign rx_load = (rx_st_q == SPM_RX_BIT) && bit_strobe && (rx_idx_q == RX_NINTH_IDX)
                   && !rx_done_q && (!mpc_q || bit_val);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_prev_q <= 1'b1;
    end else if (clk_en) begin
      rx_prev_q <= rxd_in;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= SPM_RX_IDLE;
      rx_slice_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else if (clk_en) begin
      case (rx_st_q)
        SPM_RX_IDLE: begin
          if (rx_prev_q && !rxd_in && ren_q && mode_q != SPM_SYNC) begin
            rx_st_q <= SPM_RX_BIT;
            rx_slice_q <= 4'h0;
            rx_idx_q <= 4'h0;
          end
        end
        default: begin
          if (slice_tick) begin
            rx_slice_q <= rx_slice_q + 4'h1;
          end
          if (bit_strobe) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && bit_val) begin
              rx_st_q <= SPM_RX_IDLE;
            end else if (rx_idx_q == rx_last) begin
              rx_st_q <= SPM_RX_IDLE;
            end else if (rx_idx_q != 4'h0 && rx_idx_q < RX_NINTH_IDX) begin
              rx_sh_q <= {bit_val, rx_sh_q[7:1]};
            end
          end
        end
      endcase
    end
  end

  // mode 0: shift clock on txd, data both ways on the rxd pin
  assign m0_per = m0_fast_q ? M0_PER_FAST : M0_PER_SLOW;
  assign m0_half = {1'b0, m0_per[3:1]};
  assign m0_end = m0_busy_q && (m0_ph_q == m0_per - 4'h1) && (m0_cnt_q == M0_LAST_BIT);
  assign m0_rx_go = !m0_busy_q && mode_q == SPM_SYNC && ren_q && !rx_done_q && !wr_buf;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      m0_busy_q <= 1'b0;
      m0_tx_q <= 1'b0;
      m0_sclk_q <= 1'b1;
      m0_dout_q <= 1'b1;
      m0_ph_q <= 4'h0;
      m0_cnt_q <= 4'h0;
      m0_sh_q <= 8'h00;
    end else if (clk_en) begin
      if (!m0_busy_q) begin
        m0_ph_q <= 4'h0;
        m0_cnt_q <= 4'h0;
        if (wr_buf && mode_q == SPM_SYNC) begin
          m0_busy_q <= 1'b1;
          m0_tx_q <= 1'b1;
          m0_sh_q <= w_data_q;
          m0_dout_q <= w_data_q[0];
          m0_sclk_q <= 1'b0;
        end else if (m0_rx_go) begin
          m0_busy_q <= 1'b1;
          m0_tx_q <= 1'b0;
          m0_sclk_q <= 1'b0;
        end
      end else if (m0_ph_q == m0_half - 4'h1) begin
        m0_ph_q <= m0_ph_q + 4'h1;
        m0_sclk_q <= 1'b1;
        if (!m0_tx_q) m0_sh_q <= {rxd_in, m0_sh_q[7:1]};
      end else if (m0_ph_q == m0_per - 4'h1) begin
        m0_ph_q <= 4'h0;
        m0_cnt_q <= m0_cnt_q + 4'h1;
        if (m0_end) begin
          m0_busy_q <= 1'b0;
          m0_dout_q <= 1'b1;
        end else begin
          m0_sclk_q <= 1'b0;
          if (m0_tx_q) begin
            m0_sh_q <= {1'b0, m0_sh_q[7:1]};
            m0_dout_q <= m0_sh_q[1];
          end
        end
      end else begin
        m0_ph_q <= m0_ph_q + 4'h1;
      end
    end
  end

  assign txd = (mode_q == SPM_SYNC) ? m0_sclk_q : tx_line_q;
  assign rxd_out = m0_dout_q;
  assign rxd_oe_n = !(m0_busy_q && m0_tx_q);

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SLICE_WRAP: assert property ((clk_en && rx_st_q == SPM_RX_BIT && slice_tick
      && rx_slice_q == SLICE_LAST) |=> rx_slice_q == 4'h0)
    else $error("receive slice counter did not wrap after sixteen");
  AST_FALSE_START: assert property ((rx_st_q == SPM_RX_BIT && bit_strobe && rx_idx_q == 4'h0
      && bit_val) |=> rx_st_q == SPM_RX_IDLE)
    else $error("high start bit did not abort reception");
  AST_LOAD: assert property (rx_load |=> rx_done_q && rx_buf_q == $past(rx_sh_q))
    else $error("load did not set flag and buffer");
  AST_NO_LOAD: assert property ((rx_st_q == SPM_RX_BIT && bit_strobe && rx_idx_q == RX_NINTH_IDX
      && (rx_done_q || (mpc_q && !bit_val))) |=> $stable(rx_buf_q))
    else $error("buffer loaded against the load conditions");
  AST_STOP_NINTH: assert property ((rx_load && mode_q == SPM_ASYNC10)
      |=> rx_ninth_q == $past(bit_val))
    else $error("mode 1 stop bit not placed in ninth bit field");
  AST_RX_REARM: assert property ((rx_st_q == SPM_RX_BIT && bit_strobe && rx_idx_q == rx_last
      && rx_idx_q != 4'h0) |=> rx_st_q == SPM_RX_IDLE)
    else $error("receiver not idle after middle of stop bit");
  AST_TX_START: assert property ((clk_en && tx_st_q == SPM_TX_SYNC && tx_roll && !wr_buf)
      |=> !tx_line_q && tx_st_q == SPM_TX_SHIFT)
    else $error("start bit not driven at slice roll-over");
  AST_TX_DONE: assert property (tx_fin_a |-> tx_line_q ##1 tx_done_q)
    else $error("transmit done not set after stop bit");
  AST_TX_KICK: assert property ((wr_buf) |=> (tx_st_q == SPM_TX_SYNC || m0_busy_q))
    else $error("buffer write did not start a transmission");
  AST_M0_RX: assert property (m0_rx_go && clk_en |=> m0_busy_q && !m0_tx_q)
    else $error("mode 0 reception did not start");
  AST_REN: assert property ((rx_st_q == SPM_RX_IDLE ##1 rx_st_q == SPM_RX_BIT)
      |-> $past(ren_q))
    else $error("async reception started while disabled");

  COV_RX_LOAD: cover property (rx_load);
  COV_FALSE_START: cover property (rx_st_q == SPM_RX_BIT && bit_strobe && rx_idx_q == 4'h0
      && bit_val);
  COV_TX_M2: cover property (tx_fin_a && mode_q == SPM_ASYNC11);
  COV_M0_RX: cover property (m0_end && !m0_tx_q);
endmodule // spm_serial_port

// >>> src/spm_tick_gen.sv
// slice tick generator: sixteen ticks make one asynchronous bit time
// assumes timer_ovf is a one-cycle pulse synchronous to core_clk
`timescale 1ns/1ps
module spm_tick_gen import spm_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // rate selection
  input wire spm_mode_t mode,
  input wire logic baud_dbl,
  input wire logic timer_ovf,
  // slice pulse
  output logic slice_tick
);
  logic [1:0] div_q;
  logic [1:0] lim;

  assign lim = baud_dbl ? M2_DIV_FAST : M2_DIV_SLOW;

  // mode 2 divides the oscillator, modes 1 and 3 take the timer overflow
  always_comb begin
    slice_tick = 1'b0;
    if (clk_en) begin
      case (mode)
        SPM_ASYNC11: slice_tick = (div_q == lim);
        SPM_ASYNC10, SPM_ASYNC11T: slice_tick = timer_ovf && (baud_dbl || div_q[0]);
        default: slice_tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
    end else if (clk_en) begin
      if (mode == SPM_ASYNC11) begin
        div_q <= (div_q == lim) ? 2'h0 : div_q + 2'h1;
      end else if (timer_ovf) begin
        div_q <= {1'b0, ~div_q[0]};
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_M2_FAST: assert property ((mode == SPM_ASYNC11 && baud_dbl && slice_tick) ##1 clk_en
      ##1 (clk_en && mode == SPM_ASYNC11 && baud_dbl) |-> slice_tick)
    else $error("mode 2 doubled slice spacing is not two clocks");
  AST_M2_SLOW: assert property ((mode == SPM_ASYNC11 && !baud_dbl && slice_tick) |=> !slice_tick)
    else $error("mode 2 slow slice came too soon");
endmodule // spm_tick_gen

// >>> test/spm_peer.sv
// far-side serial device: sends frames on rxd, captures frames from txd
// assumes a free-running core_clk; bit times are given in core_clk cycles
`timescale 1ns/1ps
module spm_peer (
  // clock
  input wire logic core_clk,
  // serial lines
  input wire logic txd,
  input wire logic rxd_pin,
  output logic rxd
);
  // line idles at the mark level between frames
  initial rxd = 1'b1;

  task automatic send(input logic [9:0] b, input int n, input int bc);
    rxd <= 1'b0;
    repeat (bc) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (bc) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (bc) @(posedge core_clk);
  endtask

  // short low pulse, too brief to survive the majority vote
  task automatic glitch(input int k);
    rxd <= 1'b0;
    repeat (k) @(posedge core_clk);
    rxd <= 1'b1;
    repeat (40) @(posedge core_clk);
  endtask

  // sampled on falling clock edges so registered txd has settled
  task automatic catch(input int bc, output logic [10:0] f);
    int n;
    n = 0;
    f = '1;
    while (txd !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    repeat (bc / 2) @(negedge core_clk);
    f[0] = txd;
    for (int i = 1; i < 11; i++) begin
      repeat (bc) @(negedge core_clk);
      f[i] = txd;
    end
  endtask

  // mode 0 listener: the block's data is read half a clock after each rising shift clock
  task automatic shift_in(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      @(negedge core_clk);
      v[i] = rxd_pin;
    end
  endtask

  // mode 0 talker: the next bit goes out just after the edge that took the last one
  task automatic shift_out(input logic [7:0] v);
    rxd <= v[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge txd);
      rxd <= v[i];
    end
    @(posedge txd);
    rxd <= 1'b1;
  endtask
endmodule // spm_peer

// >>> test/tb.sv
// self-checking bench for the serial port: register bus master plus peer
// assumes timer overflow every second clock, so async bits last 32 clocks with doubling on, 64 without
`timescale 1ns/1ps
module tb import spm_pkg::*; ;
  logic core_clk = 0, rst = 1, timer_ovf = 0, ce = 1;
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, d;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [1:0] r;
  logic [10:0] f;
  logic [7:0] b;
  wire awr, wr, bv, arr, rv, prx, rxo, oen, txd;
  wire [1:0] br, rr;
  wire [31:0] rd;
  // rxd pin: block drives it only when its enable is low
  wire rxp = oen ? prx : rxo;
  int n_fail = 0, total_checks = 0;

  spm_serial_port uut (.core_clk(core_clk), .rst(rst), .clk_en(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .timer_ovf(timer_ovf), .rxd_in(rxp), .rxd_out(rxo),
    .rxd_oe_n(oen), .txd(txd));
  spm_peer peer (.core_clk(core_clk), .txd(txd), .rxd_pin(rxp), .rxd(prx));

  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) timer_ovf <= ~timer_ovf;

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // readies are looked at mid-cycle, valids dropped after the taking edge
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tv;
    n = 0;
    tv = 0;
    @(posedge core_clk);
    awa <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
    while (!tv && n < 100) begin
      @(negedge core_clk);
      ta = awv & awr;
      tw = wv & wr;
      tv = bv;
      r = br;
      @(posedge core_clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      n++;
    end
    bre <= 0;
    if (n >= 100) n_fail++;
  endtask

  task automatic axr(input logic [3:0] a);
    int n;
    logic ta, tv;
    n = 0;
    tv = 0;
    @(posedge core_clk);
    ara <= a; arv <= 1; rre <= 1;
    while (!tv && n < 100) begin
      @(negedge core_clk);
      ta = arv & arr; tv = rv; d = rd; r = rr;
      @(posedge core_clk);
      if (ta) arv <= 0;
      n++;
    end
    rre <= 0;
    if (n >= 100) n_fail++;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    axr(a);
    cmp(d, e);
  endtask

  task automatic finish_test;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    axr(4'h2);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    rdc(OFF_CTRL, 32'h0000_0000);
    axw(4'h6, 32'h0000_0001);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    // mode 0 send at twelve clocks a bit, frozen mid-frame: the shift clock must hold low
    axw(OFF_BUF, 32'h0000_003C);
    cmp({31'h0, oen}, 32'h0000_0000);
    ce <= 1'b0;
    repeat (20) @(posedge core_clk);
    cmp({31'h0, txd}, 32'h0000_0000);
    ce <= 1'b1;
    peer.shift_in(b);
    cmp({24'h0, b}, 32'h0000_003C);
    repeat (20) @(posedge core_clk);
    rdc(OFF_CTRL, 32'h0000_0002);
    // mode 0 receive at four clocks a bit
    axw(OFF_PWR, 32'h0000_0001);
    axw(OFF_CTRL, 32'h0000_0010);
    peer.shift_out(8'h96);
    repeat (10) @(posedge core_clk);
    rdc(OFF_BUF, 32'h0000_0096);
    rdc(OFF_CTRL, 32'h0000_0011);
    axw(OFF_PWR, 32'h0000_0080);
    axw(OFF_CTRL, 32'h0000_0048);
    axw(OFF_BUF, 32'h0000_00A5);
    peer.catch(32, f);
    cmp({21'h0, f}, 32'h0000_074A);
    repeat (40) @(posedge core_clk);
    rdc(OFF_CTRL, 32'h0000_004A);
    axw(OFF_CTRL, 32'h0000_0050);
    peer.send(10'h03C, 9, 32);
    rdc(OFF_BUF, 32'h0000_003C);
    rdc(OFF_CTRL, 32'h0000_0051);
    // flag still set: frame must be dropped
    peer.send(10'h155, 9, 32);
    rdc(OFF_BUF, 32'h0000_003C);
    axw(OFF_CTRL, 32'h0000_0070);
    peer.send(10'h066, 9, 32);
    rdc(OFF_CTRL, 32'h0000_0070);
    peer.send(10'h199, 9, 32);
    rdc(OFF_BUF, 32'h0000_0099);
    rdc(OFF_CTRL, 32'h0000_0075);
    axw(OFF_CTRL, 32'h0000_0050);
    peer.glitch(6);
    peer.send(10'h081, 9, 32);
    rdc(OFF_BUF, 32'h0000_0081);
    axw(OFF_CTRL, 32'h0000_0090);
    peer.send(10'h0C3, 8, 32);
    rdc(OFF_BUF, 32'h0000_00C3);
    rdc(OFF_CTRL, 32'h0000_0095);
    axw(OFF_CTRL, 32'h0000_00C0);
    axw(OFF_BUF, 32'h0000_005A);
    peer.catch(32, f);
    cmp({21'h0, f}, 32'h0000_04B4);
    // mode 2 without doubling: sixty-four clocks a bit
    axw(OFF_PWR, 32'h0000_0000);
    axw(OFF_CTRL, 32'h0000_0048);
    axw(OFF_BUF, 32'h0000_00A5);
    peer.catch(64, f);
    cmp({21'h0, f}, 32'h0000_074A);
    finish_test;
  end
endmodule // tb
